// [hdl/adc_seq_defs.svh]
// Register indices, field positions, reset values and timing counts
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_PORT_A_LATCH 8'h05
`define IDX_INTERRUPT_CONTROL 8'h0B
`define IDX_PERIPHERAL_FLAG 8'h0C
`define IDX_RESULT_HIGH 8'h1E
`define IDX_CONVERTER_CONTROL 8'h1F
`define IDX_PORT_A_DIRECTION 8'h85
`define IDX_PERIPHERAL_ENABLE 8'h8C
`define IDX_RESULT_LOW 8'h9E
`define IDX_CONVERTER_CONFIG 8'h9F

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTL_CLK_SEL_HI 7
`define CTL_CLK_SEL_LO 6
`define CTL_CHAN_HI 5
`define CTL_CHAN_LO 3
`define CTL_RUN_BIT 2
`define CTL_POWER_BIT 0
`define CFG_FORMAT_BIT 7
`define CFG_PCFG_HI 3
`define CFG_PCFG_LO 0
`define INT_GLOBAL_BIT 7
`define INT_PERIPH_BIT 6
`define CONV_FLAG_BIT 6

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define RST_CONTROL 8'h00
`define RST_CONFIG 8'h00
`define RST_INTERRUPT_CONTROL 8'h00
`define RST_DIRECTION 6'h3F
`define RST_LATCH 6'h00
`define CLK_SEL_RC 2'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// Timing: system clock 10 MHz
// ----------------------------------------------------------------
`define SYS_CLK_NS 100
`define TCY_NS 400
`define RC_TAD_NS 4000
`define TCY_CYC (`TCY_NS / `SYS_CLK_NS)
`define RC_TAD_CYC (`RC_TAD_NS / `SYS_CLK_NS)
`define TAD_OSC2_CYC 2
`define TAD_OSC8_CYC 8
`define TAD_OSC32_CYC 32
`define LAST_BIT 4'h9

`endif

// [hdl/adc_seq_pkg.sv]
// Types shared by the converter sequencer and its bench
package adc_seq_pkg;

   typedef enum logic [2:0] {
      PH_IDLE = 3'b000,
      PH_FIRST = 3'b001,
      PH_SAMPLE = 3'b010,
      PH_BITS = 3'b011,
      PH_LAST = 3'b100
   } phase_t;

   typedef struct packed {
      logic awvalid;
      logic [11:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [11:0] araddr;
      logic rready;
   } axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axi_rsp_t;

   typedef struct packed {
      logic [1:0] clk_sel;
      logic [2:0] chan;
      logic busy;
      logic power;
      logic fmt;
      logic [3:0] pcfg;
      logic [5:0] latch;
      logic [5:0] dir;
      logic [7:0] interrupt_control;
      logic conv_flag;
      logic conv_en;
      logic core_off;
      phase_t phase;
      logic [5:0] cnt;
      logic [3:0] bitn;
      logic [9:0] sar;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } seq_state_t;

endpackage

// [hdl/adc_conversion_sequencer.sv]
// Conversion sequencer, result register pair and port A glue of the converter
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "adc_seq_defs.svh"

module adc_conversion_sequencer
   import adc_seq_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire axi_req_t axi_i,
   output axi_rsp_t axi_o,
   input wire logic [5:0] pin_i,
   output logic [5:0] pin_o,
   output logic [5:0] pin_oe_o,
   input wire logic sleep_i,
   input wire logic comparator_i,
   output logic [2:0] channel_o,
   output logic sample_hold_o,
   output logic [9:0] trial_code_o,
   output logic core_power_o,
   output logic irq_o,
   output logic wake_o
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   seq_state_t st_r;
   seq_state_t st_nxt;
   logic [7:0] res_hi_r;
   logic [7:0] res_hi_nxt;
   logic [7:0] res_lo_r;
   logic [7:0] res_lo_nxt;

   logic wr_go;
   logic rd_go;
   logic [7:0] wr_idx;
   logic [7:0] rd_idx;
   logic wr_hit;
   logic rd_hit;
   logic [7:0] wbyte;
   logic [5:0] analog_mask;
   logic [5:0] tad_cyc;
   logic tad_end;
   logic sleep_stop;
   logic [7:0] rd_byte;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------

   // Pins that are analog (or reference) for a port configuration code
   function automatic logic [5:0] analog_pins(input logic [3:0] code);
      logic [5:0] m;
      m = 6'h2F;
      case (code)
         4'h4, 4'h5: m = 6'h0B;
         4'h6, 4'h7: m = 6'h00;
         4'hD: m = 6'h0F;
         4'hE: m = 6'h01;
         4'hF: m = 6'h0D;
         default: m = 6'h2F;
      endcase
      return m;
   endfunction

   // Clock cycles per bit period for each clock select code
   function automatic logic [5:0] bit_period(input logic [1:0] sel);
      logic [5:0] c;
      c = 6'(`TAD_OSC2_CYC);
      case (sel)
         2'h0: c = 6'(`TAD_OSC2_CYC);
         2'h1: c = 6'(`TAD_OSC8_CYC);
         2'h2: c = 6'(`TAD_OSC32_CYC);
         default: c = 6'(`RC_TAD_CYC);
      endcase
      return c;
   endfunction

   // Register read multiplexer
   function automatic logic [7:0] read_reg(input seq_state_t s, input logic [7:0] idx,
                                           input logic [7:0] hi, input logic [7:0] lo,
                                           input logic [5:0] pins, input logic [5:0] am);
      logic [7:0] d;
      d = 8'h00;
      case (idx)
         `IDX_PORT_A_LATCH: d = {2'h0, pins & ~am};
         `IDX_INTERRUPT_CONTROL: d = s.interrupt_control;
         `IDX_PERIPHERAL_FLAG: d = {1'b0, s.conv_flag, 6'h00};
         `IDX_RESULT_HIGH: d = hi;
         `IDX_CONVERTER_CONTROL: d = {s.clk_sel, s.chan, s.busy, 1'b0, s.power};
         `IDX_PORT_A_DIRECTION: d = {2'h0, s.dir};
         `IDX_PERIPHERAL_ENABLE: d = {1'b0, s.conv_en, 6'h00};
         `IDX_RESULT_LOW: d = lo;
         `IDX_CONVERTER_CONFIG: d = {s.fmt, 3'h0, s.pcfg};
         default: d = 8'h00;
      endcase
      return d;
   endfunction

   // Index decode: word aligned, only the nine mapped indices hit; every other address is answered with SLVERR
   function automatic logic mapped(input logic [11:0] a);
      logic [7:0] i;
      logic hit;
      i = a[9:2];
      hit = 1'b0;
      case (i)
         `IDX_PORT_A_LATCH, `IDX_INTERRUPT_CONTROL, `IDX_PERIPHERAL_FLAG,
         `IDX_RESULT_HIGH, `IDX_CONVERTER_CONTROL, `IDX_PORT_A_DIRECTION,
         `IDX_PERIPHERAL_ENABLE, `IDX_RESULT_LOW, `IDX_CONVERTER_CONFIG: hit = 1'b1;
         default: hit = 1'b0;
      endcase
      return hit & (a[11:10] == 2'h0);
   endfunction

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------

   // Write address and data are taken together once both are offered
   assign wr_go = axi_i.awvalid & axi_i.wvalid & ~st_r.bvalid;
   assign rd_go = axi_i.arvalid & ~st_r.rvalid;
   assign wr_idx = axi_i.awaddr[9:2];
   assign rd_idx = axi_i.araddr[9:2];
   assign wr_hit = mapped(axi_i.awaddr);
   assign rd_hit = mapped(axi_i.araddr);
   assign wbyte = axi_i.wdata[7:0];
   assign analog_mask = analog_pins(st_r.pcfg);
   assign rd_byte = read_reg(st_r, rd_idx, res_hi_r, res_lo_r, pin_i, analog_mask);

   // Bit period timing and sleep shutdown of oscillator-clocked conversions
   assign tad_cyc = bit_period(st_r.clk_sel);
   assign tad_end = (st_r.cnt == 6'h01);
   assign sleep_stop = sleep_i & (st_r.clk_sel != `CLK_SEL_RC);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      res_hi_nxt = res_hi_r;
      res_lo_nxt = res_lo_r;

      // Response channels drop once accepted
      if (st_r.bvalid & axi_i.bready) begin
         st_nxt.bvalid = 1'b0;
      end
      if (st_r.rvalid & axi_i.rready) begin
         st_nxt.rvalid = 1'b0;
      end

      // Bit period counter runs while a conversion is under way
      if (st_r.phase != PH_IDLE) begin
         st_nxt.cnt = tad_end ? tad_cyc : st_r.cnt - 6'h01;
      end

      // Conversion sequence; channel and direction never gate it
      case (st_r.phase)
         PH_IDLE: begin
            st_nxt.cnt = 6'h00;
         end
         PH_FIRST: begin
            if (tad_end) begin
               st_nxt.phase = PH_SAMPLE;
            end
         end
         PH_SAMPLE: begin
            if (tad_end) begin
               st_nxt.phase = PH_BITS;
               st_nxt.bitn = `LAST_BIT;
               st_nxt.sar = 10'h200;
            end
         end
         PH_BITS: begin
            if (tad_end) begin
               // Keep the trial bit when the input is at or above the trial code
               st_nxt.sar[st_r.bitn] = comparator_i;
               if (st_r.bitn == 4'h0) begin
                  st_nxt.phase = PH_LAST;
               end else begin
                  st_nxt.bitn = st_r.bitn - 4'h1;
                  st_nxt.sar[st_r.bitn - 4'h1] = 1'b1;
               end
            end
         end
         PH_LAST: begin
            if (tad_end) begin
               // Twelve bit periods after the first segment: completion
               st_nxt.phase = PH_IDLE;
               st_nxt.busy = 1'b0;
               st_nxt.conv_flag = 1'b1;
               if (sleep_i & ~st_r.conv_en) begin
                  st_nxt.core_off = 1'b1;
               end
            end
         end
         default: begin
            st_nxt.phase = PH_IDLE;
         end
      endcase

      // Sleep with an oscillator clock aborts and shuts the module down
      if (sleep_stop & (st_r.phase != PH_IDLE)) begin
         st_nxt.phase = PH_IDLE;
         st_nxt.busy = 1'b0;
         st_nxt.core_off = 1'b1;
      end

      // Register writes
      if (wr_go) begin
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
         if (wr_hit & axi_i.wstrb[0]) begin
            case (wr_idx)
               `IDX_PORT_A_LATCH: st_nxt.latch = wbyte[5:0];
               `IDX_INTERRUPT_CONTROL: st_nxt.interrupt_control = wbyte;
               `IDX_PERIPHERAL_FLAG: st_nxt.conv_flag = wbyte[`CONV_FLAG_BIT];
               `IDX_RESULT_HIGH: res_hi_nxt = wbyte;
               `IDX_PORT_A_DIRECTION: st_nxt.dir = wbyte[5:0];
               `IDX_PERIPHERAL_ENABLE: st_nxt.conv_en = wbyte[`CONV_FLAG_BIT];
               `IDX_RESULT_LOW: res_lo_nxt = wbyte;
               `IDX_CONVERTER_CONFIG: begin
                  st_nxt.fmt = wbyte[`CFG_FORMAT_BIT];
                  st_nxt.pcfg = wbyte[`CFG_PCFG_HI:`CFG_PCFG_LO];
               end
               `IDX_CONVERTER_CONTROL: begin
                  st_nxt.clk_sel = wbyte[`CTL_CLK_SEL_HI:`CTL_CLK_SEL_LO];
                  st_nxt.chan = wbyte[`CTL_CHAN_HI:`CTL_CHAN_LO];
                  st_nxt.power = wbyte[`CTL_POWER_BIT];
                  st_nxt.core_off = 1'b0;
                  if (~wbyte[`CTL_RUN_BIT] | ~wbyte[`CTL_POWER_BIT]) begin
                     // Abort: back to acquisition, result pair untouched
                     st_nxt.busy = 1'b0;
                     st_nxt.phase = PH_IDLE;
                  end else if (~st_r.busy & st_r.power) begin
                     // Start only if powered before this write
                     st_nxt.busy = 1'b1;
                     st_nxt.phase = PH_FIRST;
                     // First segment: one instruction cycle for RC, else one bit period
                     st_nxt.cnt = (wbyte[`CTL_CLK_SEL_HI:`CTL_CLK_SEL_LO] == `CLK_SEL_RC) ?
                                  6'(`TCY_CYC) : bit_period(wbyte[`CTL_CLK_SEL_HI:`CTL_CLK_SEL_LO]);
                  end
               end
               default: begin
                  st_nxt.bresp = `RESP_SLVERR;
               end
            endcase
         end
      end

      // Completion loads the pair after any software write to it
      if ((st_r.phase == PH_LAST) & tad_end & ~(sleep_stop)) begin
         if (st_r.fmt) begin
            res_hi_nxt = {6'h00, st_nxt.sar[9:8]};
            res_lo_nxt = st_nxt.sar[7:0];
         end else begin
            res_hi_nxt = st_nxt.sar[9:2];
            res_lo_nxt = {st_nxt.sar[1:0], 6'h00};
         end
         // The hardware set wins over a same-cycle software clear
         st_nxt.conv_flag = 1'b1;
      end
      if (sleep_stop & (st_r.phase == PH_LAST)) begin
         st_nxt.conv_flag = st_r.conv_flag;
      end

      // Register reads
      if (rd_go) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
         st_nxt.rdata = rd_hit ? {24'h000000, rd_byte} : 32'h00000000;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------

   // Control state: reset forces registers, module off and any conversion aborted
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_r <= '{clk_sel: 2'h0, chan: 3'h0, busy: 1'b0, power: 1'b0,
                   fmt: 1'b0, pcfg: 4'h0,
                   latch: `RST_LATCH, dir: `RST_DIRECTION, interrupt_control: `RST_INTERRUPT_CONTROL,
                   conv_flag: 1'b0, conv_en: 1'b0, core_off: 1'b0,
                   phase: PH_IDLE, cnt: 6'h00, bitn: 4'h0, sar: 10'h000,
                   bvalid: 1'b0, bresp: 2'h0, rvalid: 1'b0, rdata: 32'h00000000,
                   rresp: 2'h0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // Result pair has no reset: its contents survive every reset
   always_ff @(posedge sys_clk_i) begin
      res_hi_r <= res_hi_nxt;
      res_lo_r <= res_lo_nxt;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------

   // Bus answers
   assign axi_o.awready = wr_go;
   assign axi_o.wready = wr_go;
   assign axi_o.bvalid = st_r.bvalid;
   assign axi_o.bresp = st_r.bresp;
   assign axi_o.arready = rd_go;
   assign axi_o.rvalid = st_r.rvalid;
   assign axi_o.rdata = st_r.rdata;
   assign axi_o.rresp = st_r.rresp;

   // Port A pins follow latch and direction regardless of analog use
   assign pin_o = st_r.latch;
   assign pin_oe_o = ~st_r.dir;

   // Analog core control: track except from the sample point to completion
   assign channel_o = st_r.chan;
   assign sample_hold_o = (st_r.phase == PH_IDLE) | (st_r.phase == PH_FIRST);
   assign trial_code_o = st_r.sar;
   assign core_power_o = st_r.power & ~st_r.core_off & ~sleep_stop;

   // Interrupt and wake-up
   assign irq_o = st_r.conv_flag & st_r.conv_en & st_r.interrupt_control[`INT_PERIPH_BIT]
                  & st_r.interrupt_control[`INT_GLOBAL_BIT];
   assign wake_o = st_r.conv_flag & st_r.conv_en;

endmodule // adc_conversion_sequencer

// [dv/adc_core_model.sv]
// Behavioural sample-hold and comparator of the analog converter core
`timescale 1ns/1ns
module adc_core_model (
   input wire logic sys_clk_i,
   input wire logic core_power_i,
   input wire logic sample_hold_i,
   input wire logic [9:0] trial_code_i,
   input wire logic [9:0] level_i,
   output logic comparator_o
);
   logic [9:0] held_r = 10'h000;
   logic tog_r = 1'b0;

   // Track the input while the switch is closed, keep it once opened
   always @(posedge sys_clk_i) begin
      tog_r <= ~tog_r;
      if (sample_hold_i) begin
         held_r <= level_i;
      end
   end

   // An unpowered comparator gives no useful answer
   assign comparator_o = core_power_i ? (held_r >= trial_code_i) : tog_r;
endmodule // adc_core_model

// [dv/adc_conversion_sequencer_monitor.sv]
// Port checker of the converter sequencer
`timescale 1ns/1ns
module adc_seq_checker
   import adc_seq_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire axi_req_t axi_i,
   input wire axi_rsp_t axi_o,
   input wire logic [5:0] pin_o,
   input wire logic [5:0] pin_oe_o,
   input wire logic sample_hold_o,
   input wire logic core_power_o,
   input wire logic irq_o,
   input wire logic wake_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   // ----------------------------------------
   // Register bus answers
   // ----------------------------------------
   a_write_answer: assert property (axi_i.awvalid && axi_i.wvalid && !axi_o.bvalid |=> axi_o.bvalid)
      else $error("write taken without response");
   a_read_answer: assert property (axi_i.arvalid && !axi_o.rvalid |=> axi_o.rvalid)
      else $error("read taken without response");
   a_bresp_stands: assert property (axi_o.bvalid && !axi_i.bready |=> axi_o.bvalid && $stable(axi_o.bresp))
      else $error("write response dropped early");
   a_rdata_stands: assert property (axi_o.rvalid && !axi_i.rready |=> axi_o.rvalid && $stable(axi_o.rdata))
      else $error("read data dropped early");

   // ----------------------------------------
   // Converter behaviour
   // ----------------------------------------
   a_irq_needs_wake: assert property (irq_o |-> wake_o)
      else $error("interrupt without enabled flag");
   a_unpowered_idle: assert property (!core_power_o |=> sample_hold_o)
      else $error("conversion runs with core off");
   a_reset_state: assert property ($fell(rst_i) |-> pin_oe_o == 6'h00 && pin_o == 6'h00
      && !core_power_o && sample_hold_o)
      else $error("state after reset wrong");
   a_first_segment: assert property ($fell(sample_hold_o) |-> $past(sample_hold_o, 2))
      else $error("first segment too short");
endmodule // adc_seq_checker

bind adc_conversion_sequencer adc_seq_checker i_adc_seq_checker (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
   .axi_i(axi_i), .axi_o(axi_o), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .sample_hold_o(sample_hold_o),
   .core_power_o(core_power_o), .irq_o(irq_o), .wake_o(wake_o));

// [dv/tb_adc_conversion_sequencer.sv]
// Register-level testbench of the converter sequencer
`timescale 1ns/1ns
`include "adc_seq_defs.svh"
module tb_adc_conversion_sequencer
   import adc_seq_pkg::*;
;
   logic sys_clk_i;
   logic rst_i;
   logic sleep_i;
   logic comparator_i;
   logic [5:0] pin_i;
   logic [9:0] level;
   axi_req_t req;
   axi_rsp_t rsp;
   logic [5:0] pin_o, pin_oe_o;
   logic [2:0] channel_o;
   logic [9:0] trial_code_o;
   logic sample_hold_o, core_power_o, irq_o, wake_o;
   logic [31:0] rdv;
   logic [1:0] rrs;
   logic [9:0] lv [4] = '{10'h2D7, 10'h3FF, 10'h000, 10'h155};
   logic [3:0] pc [3] = '{4'h0, 4'h6, 4'hE};
   logic [7:0] pe [3] = '{8'h10, 8'h3F, 8'h3E};
   int n_errors = 0;
   int n_checks = 0;
   int ncyc = 0;

   adc_conversion_sequencer i_adc_conversion_sequencer (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .axi_i(req),
      .axi_o(rsp), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .sleep_i(sleep_i),
      .comparator_i(comparator_i), .channel_o(channel_o), .sample_hold_o(sample_hold_o),
      .trial_code_o(trial_code_o), .core_power_o(core_power_o), .irq_o(irq_o), .wake_o(wake_o));
   adc_core_model i_adc_core_model (.sys_clk_i(sys_clk_i), .core_power_i(core_power_o),
      .sample_hold_i(sample_hold_o), .trial_code_i(trial_code_o), .level_i(level), .comparator_o(comparator_i));

   // Clock and cycle count
   initial begin
      sys_clk_i = 1'b0;
      forever #50 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) ncyc <= ncyc + 1;

   // ----------------------------------------
   // Bus tasks and comparison
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] ix, input logic [7:0] d);
      int n;
      n = 0;
      req.awaddr <= {2'b00, ix, 2'b00};
      req.wdata <= {24'h000000, d};
      req.wstrb <= 4'hF;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (!(rsp.awready && rsp.wready) && n < 50);
      req.awvalid <= 1'b0;
      req.wvalid <= 1'b0;
      while (rsp.bvalid !== 1'b1 && n < 100) begin
         @(posedge sys_clk_i);
         n++;
      end
      req.bready <= 1'b0;
      // A handshake that never completes counts as a mismatch
      if (n >= 50) begin
         n_errors++;
         $display("BAD t=%0t write handshake timed out got=%h exp=%h", $time, n, 2);
      end
      @(posedge sys_clk_i);
   endtask

   task automatic rd(input logic [7:0] ix);
      int n;
      n = 0;
      req.araddr <= {2'b00, ix, 2'b00};
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (rsp.arready !== 1'b1 && n < 50);
      req.arvalid <= 1'b0;
      while (rsp.rvalid !== 1'b1 && n < 100) begin
         @(posedge sys_clk_i);
         n++;
      end
      rdv = rsp.rdata;
      rrs = rsp.rresp;
      req.rready <= 1'b0;
      // A handshake that never completes counts as a mismatch
      if (n >= 50) begin
         n_errors++;
         $display("BAD t=%0t read handshake timed out got=%h exp=%h", $time, n, 2);
      end
      @(posedge sys_clk_i);
   endtask

   task automatic rc(input logic [7:0] ix, input logic [31:0] e);
      rd(ix);
      chk(rdv, e);
   endtask

   function automatic logic [15:0] just(input logic f, input logic [9:0] l);
      return f ? {6'h00, l} : {l, 6'h00};
   endfunction

   // Power on, start in a separate write, poll to the end, check time and result
   task automatic cc(input logic [1:0] cs, input logic f, input logic [9:0] l);
      int t0;
      int per;
      logic [15:0] jp;
      per = (cs == 2'h3) ? 40 : (2 << (2 * cs));
      jp = just(f, l);
      level = l;
      wr(`IDX_CONVERTER_CONFIG, {f, 7'h00});
      wr(`IDX_CONVERTER_CONTROL, {cs, 1'b0, cs, 3'b001});
      wr(`IDX_CONVERTER_CONTROL, {cs, 1'b0, cs, 3'b101});
      t0 = ncyc;
      rdv = 32'h4;
      while (rdv[2] !== 1'b0 && ncyc - t0 < 3000) rd(`IDX_CONVERTER_CONTROL);
      chk(32'(ncyc - t0 >= 12 * per && ncyc - t0 <= 13 * per + 12), 32'h1);
      chk(rdv, {24'h000000, cs, 1'b0, cs, 3'b001});
      rc(`IDX_RESULT_HIGH, {24'h000000, jp[15:8]});
      rc(`IDX_RESULT_LOW, {24'h000000, jp[7:0]});
      rc(`IDX_PERIPHERAL_FLAG, 32'h40);
      wr(`IDX_PERIPHERAL_FLAG, 8'h00);
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Watchdog against a hung handshake
   initial begin
      #2_000_000;
      n_errors++;
      complete_run();
   end

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      req = '0;
      rst_i = 1'b1;
      sleep_i = 1'b0;
      pin_i = 6'h3F;
      level = 10'h000;
      repeat (2) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      rc(`IDX_CONVERTER_CONTROL, 32'h00);
      rc(`IDX_CONVERTER_CONFIG, 32'h00);
      rc(`IDX_PORT_A_DIRECTION, 32'h3F);
      rd(8'h40);
      chk(32'(rrs), 32'h2);
      wr(`IDX_PORT_A_LATCH, 8'h15);
      wr(`IDX_PORT_A_DIRECTION, 8'h0F);
      chk(32'(pin_o), 32'h15);
      chk(32'(pin_oe_o), 32'h30);
      for (int i = 0; i < 3; i++) begin
         wr(`IDX_CONVERTER_CONFIG, {4'h0, pc[i]});
         rc(`IDX_PORT_A_LATCH, 32'(pe[i]));
      end
      wr(`IDX_RESULT_HIGH, 8'hA5);
      wr(`IDX_RESULT_LOW, 8'h5A);
      rc(`IDX_RESULT_HIGH, 32'hA5);
      rc(`IDX_RESULT_LOW, 32'h5A);
      $display("end: registers");
      for (int i = 0; i < 4; i++) begin
         wr(`IDX_PORT_A_DIRECTION, i[1] ? 8'h00 : 8'h3F);
         cc(i[1:0], i[0], lv[i]);
      end
      $display("end: conversions");
      wr(`IDX_CONVERTER_CONFIG, 8'h00);
      for (int ie = 1; ie >= 0; ie--) begin
         level = 10'h1A3;
         wr(`IDX_PERIPHERAL_ENABLE, ie[0] ? 8'h40 : 8'h00);
         wr(`IDX_CONVERTER_CONTROL, 8'hC1);
         wr(`IDX_CONVERTER_CONTROL, 8'hC5);
         sleep_i <= 1'b1;
         repeat (600) @(posedge sys_clk_i);
         chk(32'(wake_o), 32'(ie));
         chk(32'(core_power_o), 32'(ie));
         rc(`IDX_CONVERTER_CONTROL, 32'hC1);
         rc(`IDX_RESULT_HIGH, 32'h68);
         rc(`IDX_RESULT_LOW, 32'hC0);
         wr(`IDX_INTERRUPT_CONTROL, 8'h80);
         chk(32'(irq_o), 32'h0);
         wr(`IDX_INTERRUPT_CONTROL, 8'hC0);
         chk(32'(irq_o), 32'(ie));
         wr(`IDX_INTERRUPT_CONTROL, 8'h00);
         wr(`IDX_PERIPHERAL_FLAG, 8'h00);
         sleep_i <= 1'b0;
      end
      $display("end: sleep");
      for (int k = 0; k < 3; k++) begin
         wr(`IDX_CONVERTER_CONTROL, 8'h81);
         wr(`IDX_CONVERTER_CONTROL, 8'h85);
         repeat (60) @(posedge sys_clk_i);
         if (k == 0) begin
            wr(`IDX_CONVERTER_CONTROL, 8'h81);
         end else if (k == 1) begin
            sleep_i <= 1'b1;
            repeat (3) @(posedge sys_clk_i);
            chk(32'(core_power_o), 32'h0);
            sleep_i <= 1'b0;
         end else begin
            rst_i <= 1'b1;
            repeat (2) @(posedge sys_clk_i);
            rst_i <= 1'b0;
         end
         repeat (500) @(posedge sys_clk_i);
         chk(32'(sample_hold_o), 32'h1);
         rc(`IDX_CONVERTER_CONTROL, k == 2 ? 32'h00 : 32'h81);
         rc(`IDX_RESULT_HIGH, 32'h68);
         rc(`IDX_RESULT_LOW, 32'hC0);
      end
      rc(`IDX_PORT_A_DIRECTION, 32'h3F);
      cc(2'h1, 1'b0, 10'h2C6);
      $display("end: aborts");
      complete_run();
   end
endmodule // tb_adc_conversion_sequencer
